// *** hdl/cfgs_map.svh ***
/*
  Register offsets, field positions and fixed values of the configuration
  header slice. Assumes byte addressing of configuration space.
*/
`ifndef CFGS_MAP_SVH
`define CFGS_MAP_SVH

// ----------------------------------------------------------------------
// offsets (byte addresses in configuration space)
// ----------------------------------------------------------------------
`define CFGS_OFF_STATUS    8'h06
`define CFGS_OFF_REVISION  8'h08
`define CFGS_OFF_SUBCLASS  8'h0a
`define CFGS_OFF_BASECLASS 8'h0b
`define CFGS_OFF_HEADER    8'h0e
`define CFGS_OFF_BOARDVEN  8'h2c

// ----------------------------------------------------------------------
// fixed values, vendor reset value and field bit positions
// ----------------------------------------------------------------------
`define CFGS_STATUS_VAL    16'h0080
`define CFGS_SUBCLASS_VAL  8'h80
`define CFGS_BASECLASS_VAL 8'h08
`define CFGS_HEADER_VAL    8'h80
`define CFGS_BOARDVEN_RST  16'h0000
`define CFGS_B2B_BIT       7
`define CFGS_TIMING_LO     9
`define CFGS_TIMING_HI     10
`define CFGS_CAPLIST_BIT   4

`endif

// *** hdl/cfgs_pkg.sv ***
/*
  Types for the configuration header slice.
  Assumes cfgs_map.svh supplies the numeric constants.
*/
`default_nettype none

package cfgs_pkg;

  // one configuration access, dword-addressed with byte enables
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  dw_addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfgs_req_t;

endpackage

`default_nettype wire

// *** hdl/cfgs_header.sv ***
/*
  Status, class, revision, header-layout and write-once board vendor
  registers of a function's configuration header.
  Assumes a synchronous single-cycle configuration access port on mclk_i;
  read data answers one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfgs_map.svh"

module cfgs_header
  import cfgs_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5a  // arbitrary value
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire cfgs_req_t   req_i,
  output logic [31:0]      rdata_o,
  output logic             rvalid_o,
  output logic             vendor_locked_o
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [5:0] dw, input logic [7:0] off);
    hit = (dw == off[7:2]);
  endfunction

  // any dword that carries at least one register of this slice
  function automatic logic mapped(input logic [5:0] dw);
    mapped = hit(dw, `CFGS_OFF_STATUS) || hit(dw, `CFGS_OFF_REVISION)
             || hit(dw, `CFGS_OFF_HEADER) || hit(dw, `CFGS_OFF_BOARDVEN);
  endfunction

  logic [15:0] status_w;
  logic [15:0] vendor_q;
  logic        lock_q;
  logic        vend_wr;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // the read path packs sub class and base class into the revision dword
  // at fixed lanes; a map edit that moves them would read back garbage
  // instead of failing loudly, so refuse such a map here
  localparam logic [7:0]  OFF_REV  = `CFGS_OFF_REVISION;
  localparam logic [7:0]  OFF_SUB  = `CFGS_OFF_SUBCLASS;
  localparam logic [7:0]  OFF_BASE = `CFGS_OFF_BASECLASS;
  localparam logic [7:0]  OFF_STAT = `CFGS_OFF_STATUS;
  localparam logic [7:0]  OFF_HDR  = `CFGS_OFF_HEADER;
  localparam logic [7:0]  OFF_VEN  = `CFGS_OFF_BOARDVEN;
  localparam logic [15:0] VEND_RST = `CFGS_BOARDVEN_RST;

  if ((OFF_SUB[7:2] != OFF_REV[7:2]) || (OFF_BASE[7:2] != OFF_REV[7:2])
      || (OFF_SUB[1:0] != 2'd2) || (OFF_BASE[1:0] != 2'd3)) begin : g_bad_class
    $error("class bytes are not in the upper lanes of the revision dword");
  end

  if ((OFF_STAT[1:0] != 2'd2) || (OFF_HDR[1:0] != 2'd2)
      || (OFF_VEN[1:0] != 2'd0)) begin : g_bad_lane
    $error("status, header or vendor offset is not on its expected lane");
  end

  if (`CFGS_TIMING_HI != `CFGS_TIMING_LO + 1) begin : g_bad_timing
    $error("select timing field must be two adjacent bits");
  end

  // every status bit is a constant: errors, timing, reserved, caplist zero
  always_comb begin
    status_w = `CFGS_STATUS_VAL;
    status_w[`CFGS_TIMING_HI:`CFGS_TIMING_LO] = 2'b00;
    status_w[`CFGS_B2B_BIT] = 1'b1;
    status_w[`CFGS_CAPLIST_BIT] = 1'b0;
  end

  assign vend_wr = req_i.wr && hit(req_i.dw_addr, `CFGS_OFF_BOARDVEN)
                   && (|req_i.be[1:0]);

  // ----------------------------------------------------------------------
  // write-once board vendor code
  // ----------------------------------------------------------------------
  // one flop group per byte lane; a lane that the first write leaves
  // untouched keeps its reset value for good, since that write locks both
  logic [7:0] vendor_lane_q [2];

  for (genvar g = 0; g < 2; g++) begin : g_lane
    always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        vendor_lane_q[g] <= VEND_RST[g*8 +: 8];
      end else if (vend_wr && !lock_q && req_i.be[g]) begin
        vendor_lane_q[g] <= req_i.wdata[g*8 +: 8];
      end
    end
  end

  assign vendor_q = {vendor_lane_q[1], vendor_lane_q[0]};

  // either low lane of the first write locks; only reset unlocks
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= 1'b0;
    end else if (vend_wr) begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vendor_locked_o <= 1'b0;
    end else begin
      vendor_locked_o <= lock_q | vend_wr;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o  <= 32'h0000_0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      rdata_o  <= 32'h0000_0000;
      if (req_i.rd) begin
        if (hit(req_i.dw_addr, `CFGS_OFF_STATUS)) begin
          rdata_o[31:16] <= status_w;
        end else if (hit(req_i.dw_addr, `CFGS_OFF_REVISION)) begin
          rdata_o[7:0]   <= REVISION;
          rdata_o[23:16] <= `CFGS_SUBCLASS_VAL;
          rdata_o[31:24] <= `CFGS_BASECLASS_VAL;
        end else if (hit(req_i.dw_addr, `CFGS_OFF_HEADER)) begin
          rdata_o[23:16] <= `CFGS_HEADER_VAL;
        end else if (hit(req_i.dw_addr, `CFGS_OFF_BOARDVEN)) begin
          rdata_o[15:0] <= vendor_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  status_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_STATUS)
    |=> rdata_o[31:16] == 16'h0080)
    else $error("status read mismatch");

  timing_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_STATUS) |=> rdata_o[26:25] == 2'b00)
    else $error("select timing not fast");

  b2b_one_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_STATUS) |=> rdata_o[23] == 1'b1)
    else $error("back to back bit lost");

  caplist_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_STATUS) |=> !rdata_o[20])
    else $error("capability list bit set");

  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_STATUS)
    |=> rdata_o[22:21] == 2'b00 && rdata_o[19:16] == 4'h0)
    else $error("reserved status bits set");

  class_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_REVISION)
    |=> rdata_o[31:16] == 16'h0880 && rdata_o[7:0] == REVISION)
    else $error("class or revision mismatch");

  header_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_HEADER) |=> rdata_o[23:16] == 8'h80)
    else $error("header layout mismatch");

  vendor_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    lock_q |=> $stable(vendor_q))
    else $error("board vendor code changed after lock");

  lock_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    vend_wr |=> lock_q ##1 lock_q)
    else $error("lock not set by write");

  lock_sticky_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    lock_q |=> lock_q)
    else $error("lock cleared without reset");

  rvalid_pulse_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd |=> rvalid_o)
    else $error("read not answered");

  rvalid_idle_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !req_i.rd |=> !rvalid_o)
    else $error("read valid without read");

  rdata_idle_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !req_i.rd |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero while idle");

  unmapped_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && !mapped(req_i.dw_addr) |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  error_bits_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_STATUS)
    |=> rdata_o[31:27] == 5'h00 && !rdata_o[24])
    else $error("error status bit set");

  status_lanes_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_STATUS)
    |=> rdata_o[15:0] == 16'h0000)
    else $error("status dword lower lanes not zero");

  revision_fixed_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_REVISION)
    |=> rdata_o[7:0] == REVISION && rdata_o[15:8] == 8'h00)
    else $error("revision code mismatch");

  base_class_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_REVISION)
    |=> rdata_o[31:24] == 8'h08)
    else $error("base class mismatch");

  header_lanes_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_HEADER)
    |=> rdata_o[31:24] == 8'h00 && rdata_o[15:0] == 16'h0000)
    else $error("header dword other lanes not zero");

  vendor_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.rd && hit(req_i.dw_addr, `CFGS_OFF_BOARDVEN)
    |=> rdata_o[15:0] == $past(vendor_q) && rdata_o[31:16] == 16'h0000)
    else $error("board vendor read mismatch");

  lane0_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    vend_wr && !lock_q && req_i.be[0]
    |=> vendor_q[7:0] == $past(req_i.wdata[7:0]))
    else $error("first write lost low byte");

  lane1_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    vend_wr && !lock_q && req_i.be[1]
    |=> vendor_q[15:8] == $past(req_i.wdata[15:8]))
    else $error("first write lost high byte");

  lane0_keep_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    vend_wr && !lock_q && !req_i.be[0] |=> $stable(vendor_q[7:0]))
    else $error("disabled low lane written");

  unlocked_reset_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !lock_q |-> vendor_q == 16'h0000)
    else $error("board vendor code changed while unlocked");

  no_lock_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.wr && hit(req_i.dw_addr, `CFGS_OFF_BOARDVEN) && req_i.be[1:0] == 2'b00
    && !lock_q |=> !lock_q)
    else $error("upper lane write set the lock");

  locked_out_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    vendor_locked_o == lock_q)
    else $error("lock output disagrees with lock");

  other_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    req_i.wr && !vend_wr |=> $stable(vendor_q) && $stable(lock_q))
    else $error("write elsewhere had a side effect");

endmodule

`default_nettype wire

// *** bench/cfgs_cfg_sw.sv ***
/*
  configuration software model: one config read or write per call.
  assumes the bench calls access() and holds mclk_i running.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgs_cfg_sw
  import cfgs_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  output var cfgs_req_t    req_o
);
  initial req_o = '0;
  task automatic access(input logic w, input logic [5:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q);
    q = 32'hxxxx_xxxx;
    @(negedge mclk_i);
    req_o = '{rd: !w, wr: w, dw_addr: a, be: be, wdata: d};
    @(negedge mclk_i);
    req_o.rd = 1'b0;
    req_o.wr = 1'b0;
    // released data is scrambled so a stale value cannot be mistaken for a hold
    req_o.wdata = ~d;
    if (!w && rvalid_i !== 1'b1)
      @(negedge mclk_i);
    if (!w && rvalid_i === 1'b1)
      q = rdata_i;
  endtask
endmodule
`default_nettype wire

// *** bench/pci_config_header_status_bench.sv ***
/*
  self-checking bench for cfgs_header.
  assumes cfgs_cfg_sw stands in for configuration software.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_config_header_status_bench;
  import cfgs_pkg::*;
  localparam logic [7:0] REV = 8'h5a;  // arbitrary value
  typedef struct {logic [5:0] a; logic [31:0] e;} row_t;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        rvalid_o;
  logic        vendor_locked_o;
  logic [31:0] rdata_o;
  logic [31:0] q;
  cfgs_req_t   req_i;
  int          mismatches = 0;
  int          checked = 0;
  row_t rows[5] = '{'{6'h01, 32'h0080_0000}, '{6'h02, {8'h08, 8'h80, 8'h00, REV}},
                    '{6'h03, 32'h0080_0000}, '{6'h0b, 32'h0}, '{6'h10, 32'h0}};

  cfgs_header #(.REVISION(REV)) i_cfgs_header (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .vendor_locked_o(vendor_locked_o));
  cfgs_cfg_sw i_cfgs_cfg_sw (.mclk_i(mclk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o),
    .req_o(req_i));

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t data %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_l(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t lock %b want %b", $time, g, e);
    end
  endtask
  task automatic rd(input logic [5:0] a);
    i_cfgs_cfg_sw.access(1'b0, a, 4'h0, 32'h0, q);
  endtask
  task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
    i_cfgs_cfg_sw.access(1'b1, a, be, d, q);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge mclk_i);
    rstn_i = 1'b1;
    // second pass writes ones first; vendor dword only gets upper lanes
    for (int p = 0; p < 2; p++) begin
      foreach (rows[i]) begin
        if (p == 1)
          wr(rows[i].a, (rows[i].a == 6'h0b) ? 4'hc : 4'hf, 32'hffff_ffff);
        rd(rows[i].a);
        chk(q, rows[i].e);
      end
      $display("test fixed values pass %0d done", p);
    end
    chk_l(vendor_locked_o, 1'b0);
    wr(6'h0b, 4'h1, 32'hffff_1234);
    chk_l(vendor_locked_o, 1'b1);
    rd(6'h0b);
    chk(q, 32'h0000_0034);
    wr(6'h0b, 4'h3, 32'h0000_abcd);
    rd(6'h0b);
    chk(q, 32'h0000_0034);
    $display("test write once done");
    @(negedge mclk_i);
    rstn_i = 1'b0;
    @(negedge mclk_i);
    rstn_i = 1'b1;
    chk_l(vendor_locked_o, 1'b0);
    rd(6'h0b);
    chk(q, 32'h0);
    wr(6'h0b, 4'h3, 32'h0000_beef);
    rd(6'h0b);
    chk(q, 32'h0000_beef);
    $display("test relock after reset done");
    tally_and_finish();
  end

  initial begin
    #(20 * 400);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
